// ---- logic/drive_monitor_data_readout.sv ----
// Read-only monitor data bank answering item polls as ASCII hex characters
`timescale 1ns/100ps

module drive_monitor_data_readout #(
	parameter bit HIGH_VOLTAGE_CLASS = 1'b0,
	parameter logic [15:0] MODEL_CODE = 16'h0A5A, // Arbitrary value
	parameter int unsigned FIRMWARE_VERSION = 1
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	// Poll request from the link
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_item,
	// Drive quantities
	input wire drive_monitor_pkg::drive_live_t live,
	input wire drive_monitor_pkg::run_cmd_t link_cmd,
	input wire drive_monitor_pkg::run_cmd_t terminal_cmd,
	input wire drive_monitor_pkg::status_flags_t status_flags,
	input wire logic general_output_one,
	input wire logic general_output_two,
	// Events
	input wire logic fault_event,
	input wire logic [15:0] fault_code,
	input wire logic run_hour_tick,
	input wire logic link_err_event,
	input wire logic [7:0] link_err_code,
	// Answer
	output logic busy,
	output logic chr_valid,
	output logic [7:0] chr_data,
	output logic chr_last,
	output logic rsp_nak,
	output logic [15:0] rsp_word
);

	// Refuse a version word the item cannot carry
	if (FIRMWARE_VERSION == 100 || FIRMWARE_VERSION > 32'h0000FFFF) begin : g_fw_check
		$error("FIRMWARE_VERSION must be 0..99 or above 100");
	end

	localparam logic [15:0] FW_WORD = FIRMWARE_VERSION[15:0];
	localparam logic [15:0] DC_MAX = HIGH_VOLTAGE_CLASS ? drive_monitor_pkg::DC_MAX_HIGH_CLASS
		: drive_monitor_pkg::DC_MAX_LOW_CLASS;

	drive_monitor_pkg::monitor_state_t s_r;
	drive_monitor_pkg::monitor_state_t s_nxt;

	logic accept;
	logic [15:0] cmd_word;
	logic [15:0] status_word;
	logic [15:0] dc_word;
	drive_monitor_pkg::run_cmd_t merged_cmd;

	assign accept = ce && req_valid && !s_r.busy;

	// Final command as seen by the drive
	assign merged_cmd = link_cmd | terminal_cmd;
	assign cmd_word = {merged_cmd.fault_reset, 8'h00, merged_cmd.general_input,
		merged_cmd.reverse_run_cmd, merged_cmd.forward_run_cmd};

	assign status_word = {status_flags.fcode_writing, 2'b00, status_flags.link_valid,
		status_flags.trip, status_flags.decelerating, status_flags.accelerating,
		status_flags.current_limit, status_flags.voltage_limit, status_flags.torque_limit,
		status_flags.dc_link_ok, status_flags.braking, status_flags.output_shutoff,
		status_flags.dc_braking, status_flags.forward_rotation, 1'b0};

	assign dc_word = (live.dc_link_voltage > DC_MAX) ? DC_MAX : live.dc_link_voltage;

	always_comb begin
		logic [15:0] word;
		logic known;
		logic signed_freq;
		word = 16'h0000;
		known = 1'b1;
		signed_freq = 1'b0;
		s_nxt = s_r;

		// Fault history shifts newest into entry zero
		if (fault_event) begin
			for (int i = drive_monitor_pkg::FAULT_DEPTH - 1; i > 0; i--) begin
				s_nxt.fault_hist[i] = s_r.fault_hist[i-1];
			end
			s_nxt.fault_hist[0] = fault_code;
		end
		if (run_hour_tick && s_r.run_hours != drive_monitor_pkg::HOURS_MAX) begin
			s_nxt.run_hours = s_r.run_hours + 16'h0001;
		end
		if (link_err_event) begin
			s_nxt.link_err = {8'h00, link_err_code};
		end

		case (req_item)
			drive_monitor_pkg::ITEM_FINAL_FREQ: word = live.final_frequency;
			drive_monitor_pkg::ITEM_SET_FREQ: word = live.set_frequency;
			drive_monitor_pkg::ITEM_CALC_TORQUE: word = live.calc_torque;
			drive_monitor_pkg::ITEM_TORQUE_CUR: word = live.torque_current;
			drive_monitor_pkg::ITEM_OUT_FREQ: begin
				word = live.output_frequency;
				signed_freq = 1'b1;
			end
			drive_monitor_pkg::ITEM_MOTOR_POWER: word = live.motor_power;
			drive_monitor_pkg::ITEM_OUT_CURRENT: word = live.output_current;
			drive_monitor_pkg::ITEM_OUT_VOLTAGE: word = live.output_voltage;
			drive_monitor_pkg::ITEM_CMD_WORD: word = cmd_word;
			drive_monitor_pkg::ITEM_STATUS_WORD: word = status_word;
			drive_monitor_pkg::ITEM_OUT_TERMINAL: word = {14'h0000, general_output_two, general_output_one};
			drive_monitor_pkg::ITEM_FAULT_LATEST: word = s_r.fault_hist[0];
			drive_monitor_pkg::ITEM_FAULT_SECOND: word = s_r.fault_hist[1];
			drive_monitor_pkg::ITEM_FAULT_THIRD: word = s_r.fault_hist[2];
			drive_monitor_pkg::ITEM_FAULT_FOURTH: word = s_r.fault_hist[3];
			drive_monitor_pkg::ITEM_RUN_HOURS: word = s_r.run_hours;
			drive_monitor_pkg::ITEM_DC_LINK: word = dc_word;
			drive_monitor_pkg::ITEM_MODEL_ID: word = MODEL_CODE;
			drive_monitor_pkg::ITEM_CAPACITY: word = live.rated_capacity;
			drive_monitor_pkg::ITEM_FIRMWARE: word = FW_WORD;
			drive_monitor_pkg::ITEM_LINK_ERROR: word = s_r.link_err;
			drive_monitor_pkg::ITEM_CAP_LIFE: word = live.capacitor_life;
			drive_monitor_pkg::ITEM_FAN_LIFE: word = live.fan_life;
			default: known = 1'b0;
		endcase

		case (s_r.st)
			drive_monitor_pkg::ST_IDLE: begin
				s_nxt.chr_valid = 1'b0;
				s_nxt.chr_last = 1'b0;
				if (req_valid) begin
					s_nxt.st = drive_monitor_pkg::ST_SEND;
					s_nxt.busy = 1'b1;
					s_nxt.idx = 3'h0;
					s_nxt.chars = '0;
					if (!known || req_write) begin
						// Refusal: two hex characters of the error code, stored word kept
						s_nxt.nak = 1'b1;
						s_nxt.last_idx = drive_monitor_pkg::LAST_IDX_NAK;
						if (req_write) begin
							s_nxt.chars[0] = drive_monitor_pkg::hex_char(drive_monitor_pkg::NAK_WRITE_DISABLE[7:4]);
							s_nxt.chars[1] = drive_monitor_pkg::hex_char(drive_monitor_pkg::NAK_WRITE_DISABLE[3:0]);
						end else begin
							s_nxt.chars[0] = drive_monitor_pkg::hex_char(drive_monitor_pkg::NAK_UNKNOWN_ITEM[7:4]);
							s_nxt.chars[1] = drive_monitor_pkg::hex_char(drive_monitor_pkg::NAK_UNKNOWN_ITEM[3:0]);
						end
					end else if (signed_freq) begin
						s_nxt.nak = 1'b0;
						s_nxt.word = word;
						s_nxt.last_idx = drive_monitor_pkg::LAST_IDX_SIGNED_FREQ;
						s_nxt.chars[0] = live.reverse_dir ? drive_monitor_pkg::CHAR_REVERSE
							: drive_monitor_pkg::CHAR_FWD_OR_STOP;
						for (int i = 0; i < 4; i++) begin
							s_nxt.chars[i+1] = drive_monitor_pkg::hex_char(word[15-4*i -: 4]);
						end
					end else begin
						s_nxt.nak = 1'b0;
						s_nxt.word = word;
						s_nxt.last_idx = drive_monitor_pkg::LAST_IDX_WORD;
						for (int i = 0; i < 4; i++) begin
							s_nxt.chars[i] = drive_monitor_pkg::hex_char(word[15-4*i -: 4]);
						end
					end
				end
			end
			drive_monitor_pkg::ST_SEND: begin
				s_nxt.chr_valid = 1'b1;
				s_nxt.chr_data = s_r.chars[s_r.idx];
				s_nxt.chr_last = (s_r.idx == s_r.last_idx);
				s_nxt.idx = s_r.idx + 3'h1;
				if (s_r.idx == s_r.last_idx) begin
					s_nxt.st = drive_monitor_pkg::ST_IDLE;
					s_nxt.busy = 1'b0;
				end
			end
			default: begin
				s_nxt.st = drive_monitor_pkg::ST_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
	end

	// Reset stands for power loss: link error returns to its initial value
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.link_err <= drive_monitor_pkg::LINK_ERR_INIT;
			s_r.fault_hist <= {drive_monitor_pkg::FAULT_DEPTH{drive_monitor_pkg::FAULT_NONE}};
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign busy = s_r.busy;
	assign chr_valid = s_r.chr_valid;
	assign chr_data = s_r.chr_data;
	assign chr_last = s_r.chr_last;
	assign rsp_nak = s_r.nak;
	assign rsp_word = s_r.word;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	chk_hours_count: assert property (ce && run_hour_tick && s_r.run_hours != 16'hFFFF |=>
		s_r.run_hours == $past(s_r.run_hours) + 16'h0001)
		else $error("run hours did not advance");

	chk_hours_saturate: assert property (ce && run_hour_tick && s_r.run_hours == 16'hFFFF |=>
		s_r.run_hours == 16'hFFFF)
		else $error("run hours wrapped");

	chk_fault_shift: assert property (ce && fault_event |=>
		s_r.fault_hist[0] == $past(fault_code) && s_r.fault_hist[1] == $past(s_r.fault_hist[0])
		&& s_r.fault_hist[3] == $past(s_r.fault_hist[2]))
		else $error("fault history shift wrong");

	chk_link_err_latest: assert property (ce && link_err_event |=>
		s_r.link_err == {8'h00, $past(link_err_code)})
		else $error("link error not overwritten");

	chk_link_err_cleared: assert property ($rose(resetn) |-> s_r.link_err == 16'h0000)
		else $error("link error survived reset");

	chk_write_refused: assert property (accept && req_write ##1 ce |->
		##1 chr_valid && rsp_nak && chr_data == 8'h34 && $stable(rsp_word))
		else $error("write not refused");

	chk_dir_char: assert property (accept && !req_write && req_item == 8'h09 ##1 ce |->
		##1 chr_valid && chr_data == ($past(live.reverse_dir, 2) ? 8'h2D : 8'h20))
		else $error("direction character wrong");

	chk_hex_msb: assert property (accept && !req_write && req_item == 8'h05 ##1 ce |->
		##1 chr_valid && chr_data == drive_monitor_pkg::hex_char($past(live.set_frequency[15:12], 2)))
		else $error("first hex character wrong");

	chk_cmd_zero: assert property (accept && !req_write && req_item == 8'h0D |=>
		rsp_word[14:7] == 8'h00 && rsp_word[0] == $past(link_cmd.forward_run_cmd | terminal_cmd.forward_run_cmd))
		else $error("command word wrong");

	chk_dc_limit: assert property (accept && !req_write && req_item == 8'h15 |=>
		rsp_word <= DC_MAX)
		else $error("dc link value above class range");

	chk_status_trip: assert property (accept && !req_write && req_item == 8'h0E |=>
		rsp_word[11] == $past(status_flags.trip) && rsp_word[14:13] == 2'b00)
		else $error("status trip bit wrong");

	chk_status_low: assert property (accept && !req_write && req_item == 8'h0E |=>
		rsp_word[0] == 1'b0 && rsp_word[5] == $past(status_flags.dc_link_ok)
		&& rsp_word[1] == $past(status_flags.forward_rotation))
		else $error("status low bits wrong");

	chk_status_high: assert property (accept && !req_write && req_item == 8'h0E |=>
		rsp_word[15] == $past(status_flags.fcode_writing) && rsp_word[12] == $past(status_flags.link_valid))
		else $error("status high bits wrong");

	chk_cmd_inputs: assert property (accept && !req_write && req_item == 8'h0D |=>
		rsp_word[6:2] == $past(link_cmd.general_input | terminal_cmd.general_input)
		&& rsp_word[15] == $past(link_cmd.fault_reset | terminal_cmd.fault_reset))
		else $error("command inputs wrong");

	chk_term_bits: assert property (accept && !req_write && req_item == 8'h0F |=>
		rsp_word[15:2] == 14'h0000 && rsp_word[1] == $past(general_output_two)
		&& rsp_word[0] == $past(general_output_one))
		else $error("output terminal word wrong");

	chk_setpoint_word: assert property (accept && !req_write && req_item == 8'h05 |=>
		rsp_word == $past(live.set_frequency))
		else $error("setpoint word wrong");

	chk_torque_word: assert property (accept && !req_write && req_item == 8'h07 |=>
		rsp_word == $past(live.calc_torque))
		else $error("torque word wrong");

	chk_torque_cur_word: assert property (accept && !req_write && req_item == 8'h08 |=>
		rsp_word == $past(live.torque_current))
		else $error("torque current word wrong");

	chk_out_freq_word: assert property (accept && !req_write && req_item == 8'h09 |=>
		rsp_word == $past(live.output_frequency) && s_r.last_idx == 3'h4)
		else $error("output frequency word wrong");

	chk_power_word: assert property (accept && !req_write && req_item == 8'h0A |=>
		rsp_word == $past(live.motor_power))
		else $error("motor power word wrong");

	chk_current_word: assert property (accept && !req_write && req_item == 8'h0B |=>
		rsp_word == $past(live.output_current))
		else $error("output current word wrong");

	chk_write_word_kept: assert property (accept && req_write |=>
		rsp_word == $past(rsp_word) && rsp_nak)
		else $error("refused write changed the word");

	chk_write_second_char: assert property (accept && req_write ##1 ce ##1 ce |->
		##1 chr_valid && chr_data == 8'h46 && chr_last)
		else $error("write refusal code wrong");

	chk_link_err_hold: assert property (ce && !link_err_event |=>
		s_r.link_err == $past(s_r.link_err))
		else $error("link error changed without event");

	chk_fault_hold: assert property (ce && !fault_event |=>
		s_r.fault_hist == $past(s_r.fault_hist))
		else $error("fault history changed without event");

	chk_freeze_state: assert property (!ce |=>
		s_r == $past(s_r))
		else $error("state moved with enable low");

	chk_busy_last: assert property (chr_valid && chr_last |->
		!busy)
		else $error("busy still high on last character");

endmodule : drive_monitor_data_readout

// ---- common/drive_monitor_pkg.sv ----
// Constants, types and helpers shared by the monitor data readout
package drive_monitor_pkg;

	localparam int unsigned WORD_W = 16;

	// Monitor item numbers as carried in the request
	localparam logic [7:0] ITEM_FINAL_FREQ = 8'h01;
	localparam logic [7:0] ITEM_SET_FREQ = 8'h05;
	localparam logic [7:0] ITEM_CALC_TORQUE = 8'h07;
	localparam logic [7:0] ITEM_TORQUE_CUR = 8'h08;
	localparam logic [7:0] ITEM_OUT_FREQ = 8'h09;
	localparam logic [7:0] ITEM_MOTOR_POWER = 8'h0A;
	localparam logic [7:0] ITEM_OUT_CURRENT = 8'h0B;
	localparam logic [7:0] ITEM_OUT_VOLTAGE = 8'h0C;
	localparam logic [7:0] ITEM_CMD_WORD = 8'h0D;
	localparam logic [7:0] ITEM_STATUS_WORD = 8'h0E;
	localparam logic [7:0] ITEM_OUT_TERMINAL = 8'h0F;
	localparam logic [7:0] ITEM_FAULT_LATEST = 8'h10;
	localparam logic [7:0] ITEM_FAULT_SECOND = 8'h11;
	localparam logic [7:0] ITEM_FAULT_THIRD = 8'h12;
	localparam logic [7:0] ITEM_FAULT_FOURTH = 8'h13;
	localparam logic [7:0] ITEM_RUN_HOURS = 8'h14;
	localparam logic [7:0] ITEM_DC_LINK = 8'h15;
	localparam logic [7:0] ITEM_MODEL_ID = 8'h17;
	localparam logic [7:0] ITEM_CAPACITY = 8'h18;
	localparam logic [7:0] ITEM_FIRMWARE = 8'h19;
	localparam logic [7:0] ITEM_LINK_ERROR = 8'h1A;
	localparam logic [7:0] ITEM_CAP_LIFE = 8'h2E;
	localparam logic [7:0] ITEM_FAN_LIFE = 8'h30;

	// Characters and refusal codes
	localparam logic [7:0] CHAR_FWD_OR_STOP = 8'h20;
	localparam logic [7:0] CHAR_REVERSE = 8'h2D;
	localparam logic [7:0] NAK_UNKNOWN_ITEM = 8'h4E;
	localparam logic [7:0] NAK_WRITE_DISABLE = 8'h4F;

	// Answer lengths as last character index
	localparam logic [2:0] LAST_IDX_WORD = 3'h3;
	localparam logic [2:0] LAST_IDX_SIGNED_FREQ = 3'h4;
	localparam logic [2:0] LAST_IDX_NAK = 3'h1;

	// Value limits and reset values
	localparam logic [15:0] DC_MAX_LOW_CLASS = 16'h01F4;
	localparam logic [15:0] DC_MAX_HIGH_CLASS = 16'h03E8;
	localparam logic [15:0] HOURS_MAX = 16'hFFFF;
	localparam logic [15:0] FAULT_NONE = 16'h0000;
	localparam logic [15:0] LINK_ERR_INIT = 16'h0000;
	localparam int unsigned FW_STD_MAX = 99;
	localparam int unsigned FW_NONSTD_MIN = 101;
	localparam int unsigned FAULT_DEPTH = 4;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_SEND = 1'b1
	} rd_state_t;

	typedef struct packed {
		logic fault_reset;
		logic [4:0] general_input;
		logic reverse_run_cmd;
		logic forward_run_cmd;
	} run_cmd_t;

	typedef struct packed {
		logic fcode_writing;
		logic link_valid;
		logic trip;
		logic decelerating;
		logic accelerating;
		logic current_limit;
		logic voltage_limit;
		logic torque_limit;
		logic dc_link_ok;
		logic braking;
		logic output_shutoff;
		logic dc_braking;
		logic forward_rotation;
	} status_flags_t;

	typedef struct packed {
		logic [15:0] final_frequency;
		logic [15:0] set_frequency;
		logic [15:0] calc_torque;
		logic [15:0] torque_current;
		logic [15:0] output_frequency;
		logic reverse_dir;
		logic [15:0] motor_power;
		logic [15:0] output_current;
		logic [15:0] output_voltage;
		logic [15:0] dc_link_voltage;
		logic [15:0] rated_capacity;
		logic [15:0] capacitor_life;
		logic [15:0] fan_life;
	} drive_live_t;

	typedef struct packed {
		rd_state_t st;
		logic [4:0][7:0] chars;
		logic [2:0] last_idx;
		logic [2:0] idx;
		logic chr_valid;
		logic [7:0] chr_data;
		logic chr_last;
		logic nak;
		logic busy;
		logic [15:0] word;
		logic [FAULT_DEPTH-1:0][15:0] fault_hist;
		logic [15:0] run_hours;
		logic [15:0] link_err;
	} monitor_state_t;

	function automatic logic [7:0] hex_char(input logic [3:0] nib);
		hex_char = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
	endfunction : hex_char

endpackage : drive_monitor_pkg

// ---- testbench/host_poll_model.sv ----
// Host poll model raising item requests and gathering answer characters
`timescale 1ns/100ps
module host_poll_model (
	// Clock, reset and enable
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	// Requests
	output logic req_valid,
	output logic req_write,
	output logic [7:0] req_item,
	// Answers
	input wire logic busy,
	input wire logic chr_valid,
	input wire logic [7:0] chr_data,
	input wire logic chr_last,
	input wire logic rsp_nak,
	input wire logic [15:0] rsp_word,
	// Gathered frame
	output logic rx_done,
	output logic [39:0] rx_chars,
	output logic [2:0] rx_cnt,
	output logic rx_nak,
	output logic [15:0] rx_word
);
	logic taken = 1'b0;
	logic mid = 1'b0;
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_item = 8'h00;
	end
	always @(posedge sys_clk) begin
		taken <= req_valid && !busy && ce;
		rx_done <= resetn && chr_valid && chr_last;
		mid <= resetn && chr_valid && !chr_last;
		if (chr_valid) begin
			rx_chars <= {(mid ? rx_chars[31:0] : 32'h0), chr_data};
			rx_cnt <= mid ? rx_cnt + 3'h1 : 3'h1;
			rx_nak <= rsp_nak;
			rx_word <= rsp_word;
		end
	end
	// Request held until the edge that takes it
	task automatic poll(input logic wr, input logic [7:0] item);
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_write = wr;
		req_item = item;
		repeat (200) begin
			@(posedge sys_clk);
			#1;
			if (taken)
				break;
		end
	endtask : poll
	task automatic stop;
		@(negedge sys_clk);
		req_valid = 1'b0;
		req_write = 1'b0;
		req_item = ~req_item;
	endtask : stop
endmodule : host_poll_model

// ---- testbench/tb.sv ----
// Self-checking bench for the monitor data readout
`timescale 1ns/100ps
module tb;
	typedef struct {logic [39:0] chars; logic [2:0] n; logic nak; logic [15:0] word;} note_t;
	localparam int FW = 42;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic req_valid, req_write, busy, chr_valid, chr_last, rsp_nak, rx_done, rx_nak, y1, y2, f_ev, tick, e_ev;
	logic [7:0] req_item, chr_data, e_code, cm;
	logic [15:0] rsp_word, rx_word, f_code;
	logic [39:0] rx_chars;
	logic [2:0] rx_cnt;
	logic [223:0] rnd;
	drive_monitor_pkg::drive_live_t live;
	drive_monitor_pkg::run_cmd_t l_cmd, t_cmd;
	drive_monitor_pkg::status_flags_t flags;
	logic [15:0] fc [5] = '{16'h0001, 16'h0011, 16'h0026, 16'h000A, 16'h0017};
	logic [15:0] last_word = 16'h0000;
	note_t q[$];
	note_t cur;
	integer seed = 68506;
	int error_cnt = 0;
	int checked = 0;

	always #2 sys_clk = ~sys_clk;

	// Model code value is arbitrary
	drive_monitor_data_readout #(.MODEL_CODE(16'h3C3C), .FIRMWARE_VERSION(FW)) drive_monitor_data_readout_i (
		.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .req_valid(req_valid), .req_write(req_write),
		.req_item(req_item), .live(live), .link_cmd(l_cmd), .terminal_cmd(t_cmd), .status_flags(flags),
		.general_output_one(y1), .general_output_two(y2), .fault_event(f_ev), .fault_code(f_code),
		.run_hour_tick(tick), .link_err_event(e_ev), .link_err_code(e_code), .busy(busy),
		.chr_valid(chr_valid), .chr_data(chr_data), .chr_last(chr_last), .rsp_nak(rsp_nak), .rsp_word(rsp_word));
	host_poll_model host_poll_model_i (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .req_valid(req_valid),
		.req_write(req_write), .req_item(req_item), .busy(busy), .chr_valid(chr_valid), .chr_data(chr_data),
		.chr_last(chr_last), .rsp_nak(rsp_nak), .rsp_word(rsp_word), .rx_done(rx_done), .rx_chars(rx_chars),
		.rx_cnt(rx_cnt), .rx_nak(rx_nak), .rx_word(rx_word));

	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v > 4'h9) ? 8'h37 + 8'(v) : 8'h30 + 8'(v);
	endfunction : hx

	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [7:0] item, input logic [15:0] w);
		note_t n;
		n.chars = {8'h00, hx(w[15:12]), hx(w[11:8]), hx(w[7:4]), hx(w[3:0])};
		n.n = 3'h4;
		n.nak = 1'b0;
		n.word = w;
		if (item == 8'h09) begin
			n.chars[39:32] = live.reverse_dir ? 8'h2D : 8'h20;
			n.n = 3'h5;
		end
		last_word = w;
		q.push_back(n);
		host_poll_model_i.poll(1'b0, item);
	endtask : rd

	// Refusal answer: write gives 4F, unknown item 4E
	task automatic rf(input logic wr, input logic [7:0] item);
		note_t n;
		n.chars = {24'h0, 8'h34, (wr ? 8'h46 : 8'h45)};
		n.n = 3'h2;
		n.nak = 1'b1;
		n.word = last_word;
		q.push_back(n);
		host_poll_model_i.poll(wr, item);
	endtask : rf

	task automatic drain(input string name);
		host_poll_model_i.stop();
		repeat (100)
			if (q.size() != 0)
				@(posedge sys_clk);
		check(40'(q.size()), 40'h0, "answers outstanding");
		$display("test %s done", name);
	endtask : drain

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	always @(posedge sys_clk) begin
		if (rx_done === 1'b1) begin
			if (q.size() == 0)
				check(40'h1, 40'h0, "unexpected answer");
			else begin
				cur = q.pop_front();
				check(rx_chars, cur.chars, "answer characters");
				check(40'(rx_cnt), 40'(cur.n), "answer length");
				check(40'(rx_nak), 40'(cur.nak), "refusal flag");
				check(40'(rx_word), 40'(cur.word), "held word");
			end
		end
	end

	initial begin
		repeat (70000) @(posedge sys_clk);
		error_cnt++;
		complete_run();
	end

	initial begin
		{live, l_cmd, t_cmd, flags, y1, y2, f_ev, tick, e_ev, f_code, e_code} = '0;
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		rf(1'b0, 8'h02);
		for (int i = 0; i < 4; i++)
			rd(8'h10 + 8'(i), 16'h0000);
		rd(8'h14, 16'h0000);
		drain("empty after reset");
		for (int b = 0; b < 2; b++) begin
			@(negedge sys_clk);
			for (int i = 0; i < 7; i++)
				rnd = {rnd[191:0], 32'($random(seed))};
			live = rnd[208:0];
			{l_cmd, t_cmd, flags, y1, y2} = 31'($random(seed));
			live.reverse_dir = b[0];
			if (b == 1)
				live.dc_link_voltage[15:8] = 8'h00;
			cm = l_cmd | t_cmd;
			rd(8'h01, live.final_frequency);
			rd(8'h05, live.set_frequency);
			rd(8'h07, live.calc_torque);
			rd(8'h08, live.torque_current);
			rd(8'h09, live.output_frequency);
			rd(8'h0A, live.motor_power);
			rd(8'h0B, live.output_current);
			rd(8'h0C, live.output_voltage);
			rd(8'h0D, {cm[7], 8'h00, cm[6:0]});
			rd(8'h0E, {flags[12], 2'h0, flags[11:0], 1'h0});
			rd(8'h0F, {14'h0, y2, y1});
			rd(8'h15, (live.dc_link_voltage > 16'h01F4) ? 16'h01F4 : live.dc_link_voltage);
			rd(8'h17, 16'h3C3C);
			rd(8'h18, live.rated_capacity);
			rd(8'h19, 16'(FW));
			rd(8'h2E, live.capacitor_life);
			rd(8'h30, live.fan_life);
			drain("item readout");
		end
		// Last event pulse lands with the clock enable low
		for (int i = 0; i < 5; i++) begin
			@(negedge sys_clk);
			{ce, f_ev, tick, e_ev} = {i != 4, 3'h7};
			f_code = fc[i];
			e_code = 8'h4A + 8'(i);
			@(negedge sys_clk);
			{ce, f_ev, tick, e_ev} = 4'h8;
		end
		for (int i = 0; i < 4; i++)
			rd(8'h10 + 8'(i), fc[3 - i]);
		rd(8'h14, 16'h0004);
		rd(8'h1A, 16'h004D);
		rf(1'b1, 8'h05);
		rf(1'b1, 8'h1A);
		rd(8'h1A, 16'h004D);
		rf(1'b0, 8'h16);
		rf(1'b0, 8'hFF);
		drain("events and refusals");
		@(negedge sys_clk);
		resetn = 1'b0;
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		last_word = 16'h0000;
		rd(8'h1A, 16'h0000);
		rd(8'h10, 16'h0000);
		drain("power loss");
		// Hold the hour tick long enough to reach the ceiling
		@(negedge sys_clk);
		tick = 1'b1;
		repeat (65540) @(negedge sys_clk);
		tick = 1'b0;
		rd(8'h14, 16'hFFFF);
		drain("hours saturate");
		complete_run();
	end
endmodule : tb
